/* File: hdl/cls_params.svh */
// constants of the coprocessor load/store address unit
// assumes: included by bare name from the design files
`ifndef CLS_PARAMS_SVH
`define CLS_PARAMS_SVH
// apb byte offsets
`define CLS_OFF_CTRL 8'h00
`define CLS_OFF_INSTR 8'h04
`define CLS_OFF_BASE 8'h08
`define CLS_OFF_PC 8'h0c
`define CLS_OFF_FLAGS 8'h10
`define CLS_OFF_STAT 8'h14
`define CLS_OFF_WBVAL 8'h18
`define CLS_OFF_ADDR 8'h1c
`define CLS_OFF_WORDS 8'h20
// instruction fields
`define CLS_F_COND 31:28
`define CLS_F_PRE 24
`define CLS_F_UP 23
`define CLS_F_LONG 22
`define CLS_F_WB 21
`define CLS_F_LOAD 20
`define CLS_F_BASE 19:16
`define CLS_F_OFF 7:0
// control and status bits
`define CLS_C_START 0
`define CLS_C_USER 1
`define CLS_S_BUSY 0
`define CLS_S_DONE 1
`define CLS_S_SKIP 2
`define CLS_S_AEXC 3
`define CLS_S_DABT 4
`define CLS_S_UNDEF 5
// reset values and counts
`define CLS_RST_WORD 32'h0000_0000
`define CLS_PC_IDX 4'hf
`define CLS_PC_AHEAD 26'h000_0008
`define CLS_WORD_STEP 26'h000_0004
`define CLS_CLAIM_WAIT 8'h10
`endif

/* File: hdl/cls_pkg.sv */
// types shared by the coprocessor load/store address unit
// assumes: nothing beyond the params header
package cls_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_COND, ST_CLAIM, ST_XFER} cls_state_t;
	typedef logic [25:0] cls_addr_t;
	typedef logic [3:0] cls_flags_t;
endpackage

/* File: hdl/cls_agen_if.sv */
// carrier between the sequencer, the address former and condition check
// assumes: all three sit on one clock, signals are combinational
`timescale 1ns/100ps
interface cls_agen_if;
	import cls_pkg::*;
	logic [31:0] instr;
	logic [31:0] base;
	cls_addr_t pc;
	cls_flags_t flags;
	logic pass;
	logic [31:0] xfer_addr;
	logic [31:0] wb_data;
	logic wb_en;
	logic force_translate_n;
	logic illegal;
	modport core (output instr, base, pc, flags, input pass, xfer_addr,
		wb_data, wb_en, force_translate_n, illegal);
	modport agen (input instr, base, pc, output xfer_addr, wb_data,
		wb_en, force_translate_n, illegal);
	modport cond (input instr, flags, output pass);
endinterface

/* File: hdl/cls_agen.sv */
// address former: scaled offset, up/down, pre/post index, write-back
// assumes: instruction and base held stable by the sequencer
`timescale 1ns/100ps
`include "cls_params.svh"
module cls_agen
	import cls_pkg::*;
(
	// operands and results
	cls_agen_if.agen ag
);
	wire [31:0] off_w;
	wire [31:0] base_w;
	wire [31:0] moved_w;
	wire pre_w;
	// offset is unsigned, widened and moved to word units
	assign off_w = {22'h0, ag.instr[`CLS_F_OFF], 2'b00};
	// pc base is the bare address, read-ahead added, flags never mixed in
	assign base_w = (ag.instr[`CLS_F_BASE] == `CLS_PC_IDX) ?
		{6'h00, ag.pc + `CLS_PC_AHEAD} : ag.base;
	// up adds, down subtracts: reach of 255 words either way
	assign moved_w = ag.instr[`CLS_F_UP] ? base_w + off_w :
		base_w - off_w;
	assign pre_w = ag.instr[`CLS_F_PRE];
	assign ag.xfer_addr = pre_w ? moved_w : base_w;
	assign ag.wb_data = moved_w;
	// post-index always writes back; w gates write-back only pre-indexed, and post-indexed it forces translation
	assign ag.wb_en = !pre_w || ag.instr[`CLS_F_WB];
	assign ag.force_translate_n = !pre_w && ag.instr[`CLS_F_WB];
	// only the address used is judged; wb value may leave the space
	assign ag.illegal = |ag.xfer_addr[31:26];
endmodule

/* File: hdl/cls_cond.sv */
// condition check of the instruction against the nzcv flags
// assumes: flags ordered n,z,c,v from bit 3 down
`timescale 1ns/100ps
`include "cls_params.svh"
module cls_cond
	import cls_pkg::*;
(
	// instruction and flags in, verdict out
	cls_agen_if.cond cd
);
	wire n_w;
	wire z_w;
	wire c_w;
	wire v_w;
	logic pass_c;
	assign {n_w, z_w, c_w, v_w} = cd.flags;
	// one verdict per condition code; the last code never runs
	always_comb begin
		unique case (cd.instr[`CLS_F_COND])
			4'h0: pass_c = z_w;
			4'h1: pass_c = !z_w;
			4'h2: pass_c = c_w;
			4'h3: pass_c = !c_w;
			4'h4: pass_c = n_w;
			4'h5: pass_c = !n_w;
			4'h6: pass_c = v_w;
			4'h7: pass_c = !v_w;
			4'h8: pass_c = c_w && !z_w;
			4'h9: pass_c = !c_w || z_w;
			4'ha: pass_c = n_w == v_w;
			4'hb: pass_c = n_w != v_w;
			4'hc: pass_c = !z_w && (n_w == v_w);
			4'hd: pass_c = z_w || (n_w != v_w);
			4'he: pass_c = 1'b1;
			4'hf: pass_c = 1'b0;
		endcase
	end
	assign cd.pass = pass_c;
endmodule

/* File: hdl/cls_top.sv */
// coprocessor load/store address unit: apb registers and sequencer
// assumes: coprocessor and memory logic share pclk, no synchronisers
`timescale 1ns/100ps
`include "cls_params.svh"
module cls_top
	import cls_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// coprocessor side
	output logic [31:0] cp_instr,
	output logic cp_valid,
	input wire logic cp_accept,
	input wire logic cp_last,
	// memory side
	output cls_addr_t mem_addr,
	output logic mem_req,
	output logic mem_write,
	output logic translate_n,
	input wire logic mem_ack,
	input wire logic mem_abort,
	// core side: base write-back and traps
	output logic base_wb_valid,
	output logic [3:0] base_wb_reg,
	output logic [31:0] base_wb_data,
	output logic trap_addr_exc,
	output logic trap_data_abort,
	output logic trap_undef
);
	cls_agen_if ag_if();
	cls_state_t st_r;
	logic [31:0] instr_r;
	logic [31:0] base_r;
	cls_addr_t pc_r;
	cls_flags_t flags_r;
	logic user_r;
	logic [5:1] stat_r;
	logic [31:0] wbval_r;
	logic [31:0] addr_r;
	logic [31:0] words_r;
	logic [7:0] wait_r;
	logic [31:0] prdata_r;
	logic [31:0] cp_instr_r;
	logic cp_valid_r;
	cls_addr_t mem_addr_r;
	logic mem_req_r;
	logic mem_write_r;
	logic translate_n_n_r;
	logic wb_valid_r;
	logic [31:0] wb_data_r;
	logic aexc_r;
	logic dabt_r;
	logic undef_r;

	cls_agen u_agen (
		.ag(ag_if.agen)
	);
	cls_cond u_cond (
		.cd(ag_if.cond)
	);

	// operands to the address former, held in registers while busy
	assign ag_if.instr = instr_r;
	assign ag_if.base = base_r;
	assign ag_if.pc = pc_r;
	assign ag_if.flags = flags_r;

	// apb decode
	wire setup_w = psel && !penable;
	wire access_w = psel && penable;
	wire wr_w = access_w && pwrite;
	wire busy_w = st_r != ST_IDLE;
	wire hit_w = paddr == `CLS_OFF_CTRL || paddr == `CLS_OFF_INSTR ||
		paddr == `CLS_OFF_BASE || paddr == `CLS_OFF_PC ||
		paddr == `CLS_OFF_FLAGS || paddr == `CLS_OFF_STAT ||
		paddr == `CLS_OFF_WBVAL || paddr == `CLS_OFF_ADDR ||
		paddr == `CLS_OFF_WORDS;
	// operand writes are refused while busy so the address stays put
	wire op_wr_w = wr_w && !busy_w;
	wire start_w = op_wr_w && paddr == `CLS_OFF_CTRL &&
		pwdata[`CLS_C_START];
	wire stat_wr_w = wr_w && paddr == `CLS_OFF_STAT;
	assign pready = 1'b1;
	assign pslverr = access_w && !hit_w;

	// sequencer events
	wire claim_ok_w = st_r == ST_CLAIM && cp_accept;
	wire claim_to_w = st_r == ST_CLAIM && !cp_accept &&
		wait_r == `CLS_CLAIM_WAIT - 8'h01;
	wire word_w = st_r == ST_XFER && mem_ack;
	wire end_w = word_w && (cp_last || mem_abort);
	wire skip_w = st_r == ST_COND && !ag_if.pass;
	wire exc_w = claim_ok_w && ag_if.illegal;
	wire wb_w = end_w && ag_if.wb_en;
	wire [5:1] stat_set_w = {claim_to_w, word_w && mem_abort, exc_w,
		skip_w, end_w || skip_w || exc_w || claim_to_w};

	// read data captured in the setup cycle
	logic [31:0] rd_c;
	always_comb begin
		rd_c = `CLS_RST_WORD;
		unique case (paddr)
			`CLS_OFF_CTRL: rd_c = {30'h0, user_r, 1'b0};
			`CLS_OFF_INSTR: rd_c = instr_r;
			`CLS_OFF_BASE: rd_c = base_r;
			`CLS_OFF_PC: rd_c = {6'h00, pc_r};
			`CLS_OFF_FLAGS: rd_c = {28'h0, flags_r};
			`CLS_OFF_STAT: rd_c = {26'h0, stat_r, busy_w};
			`CLS_OFF_WBVAL: rd_c = wbval_r;
			`CLS_OFF_ADDR: rd_c = addr_r;
			`CLS_OFF_WORDS: rd_c = words_r;
			default: rd_c = `CLS_RST_WORD;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= `CLS_RST_WORD;
		end else if (setup_w) begin
			prdata_r <= rd_c;
		end
	end

	// operand registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_r <= `CLS_RST_WORD;
			base_r <= `CLS_RST_WORD;
			pc_r <= '0;
			flags_r <= '0;
			user_r <= 1'b0;
		end else if (op_wr_w) begin
			if (paddr == `CLS_OFF_INSTR) instr_r <= pwdata;
			if (paddr == `CLS_OFF_BASE) base_r <= pwdata;
			if (paddr == `CLS_OFF_PC) pc_r <= pwdata[25:0];
			if (paddr == `CLS_OFF_FLAGS) flags_r <= pwdata[3:0];
			if (paddr == `CLS_OFF_CTRL) user_r <= pwdata[`CLS_C_USER];
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
		end else begin
			stat_r <= (stat_r & ~(stat_wr_w ? pwdata[5:1] : 5'h00)) |
				stat_set_w;
		end
	end

	// sequencer state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_IDLE;
		end else begin
			unique case (st_r)
				ST_IDLE: if (start_w) st_r <= ST_COND;
				ST_COND: st_r <= ag_if.pass ? ST_CLAIM : ST_IDLE;
				ST_CLAIM: begin
					if (exc_w || claim_to_w) st_r <= ST_IDLE;
					else if (claim_ok_w) st_r <= ST_XFER;
				end
				ST_XFER: if (end_w) st_r <= ST_IDLE;
			endcase
		end
	end

	// claim wait counter; no claimant within the window is undefined
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_r <= 8'h00;
		end else if (st_r == ST_CLAIM) begin
			wait_r <= wait_r + 8'h01;
		end else begin
			wait_r <= 8'h00;
		end
	end

	// offer the instruction; the matching coprocessor claims it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cp_instr_r <= `CLS_RST_WORD;
			cp_valid_r <= 1'b0;
		end else if (skip_w) begin
			cp_valid_r <= 1'b0;
		end else if (st_r == ST_COND) begin
			cp_instr_r <= instr_r;
			cp_valid_r <= 1'b1;
		end else if (claim_ok_w || claim_to_w) begin
			cp_valid_r <= 1'b0;
		end
	end

	// memory cycle: first word at the formed address, then word steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_addr_r <= '0;
			mem_req_r <= 1'b0;
			mem_write_r <= 1'b0;
			translate_n_n_r <= 1'b1;
		end else if (claim_ok_w && !ag_if.illegal) begin
			mem_addr_r <= ag_if.xfer_addr[25:0];
			mem_req_r <= 1'b1;
			mem_write_r <= !instr_r[`CLS_F_LOAD];
			// user mode, or privileged post-index with w, asks translation
			translate_n_n_r <= !(user_r || ag_if.force_translate_n);
		end else if (end_w) begin
			mem_req_r <= 1'b0;
			translate_n_n_r <= 1'b1;
		end else if (word_w) begin
			// later words wrap inside the space and are never checked
			mem_addr_r <= mem_addr_r + `CLS_WORD_STEP;
		end
	end

	// results: first address, words moved, base write-back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_r <= `CLS_RST_WORD;
			words_r <= `CLS_RST_WORD;
			wbval_r <= `CLS_RST_WORD;
			wb_valid_r <= 1'b0;
			wb_data_r <= `CLS_RST_WORD;
		end else begin
			wb_valid_r <= wb_w;
			if (claim_ok_w) addr_r <= ag_if.xfer_addr;
			if (start_w) words_r <= `CLS_RST_WORD;
			else if (word_w) words_r <= words_r + 32'h0000_0001;
			if (wb_w) begin
				wbval_r <= ag_if.wb_data;
				wb_data_r <= ag_if.wb_data;
			end
		end
	end

	// trap pulses; an abort still counts its word and does the base write-back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aexc_r <= 1'b0;
			dabt_r <= 1'b0;
			undef_r <= 1'b0;
		end else begin
			aexc_r <= exc_w;
			dabt_r <= word_w && mem_abort;
			undef_r <= claim_to_w;
		end
	end

	// outputs
	assign prdata = prdata_r;
	assign cp_instr = cp_instr_r;
	assign cp_valid = cp_valid_r;
	assign mem_addr = mem_addr_r;
	assign mem_req = mem_req_r;
	assign mem_write = mem_write_r;
	assign translate_n = translate_n_n_r;
	assign base_wb_valid = wb_valid_r;
	assign base_wb_reg = instr_r[`CLS_F_BASE];
	assign base_wb_data = wb_data_r;
	assign trap_addr_exc = aexc_r;
	assign trap_data_abort = dabt_r;
	assign trap_undef = undef_r;

	// checking helpers built apart from the address former
	wire [31:0] chk_off_w = {22'h0, instr_r[7:0], 2'b00};
	wire chk_gpr_w = instr_r[19:16] != 4'hf;
	wire [31:0] chk_up_w = base_r + chk_off_w;
	wire [31:0] chk_dn_w = base_r - chk_off_w;

	property p_cond_skip;
		@(posedge pclk) disable iff (!presetn)
		(st_r == ST_COND && !ag_if.pass) |=> st_r == ST_IDLE &&
			!cp_valid && !mem_req && stat_r[`CLS_S_SKIP];
	endproperty
	a_cond_skip: assert property (p_cond_skip)
		else $error("failed condition still started a transfer");

	property p_pre_addr;
		@(posedge pclk) disable iff (!presetn)
		(claim_ok_w && !ag_if.illegal && instr_r[24] && chk_gpr_w) |=>
			mem_req && mem_addr == (instr_r[23] ? $past(chk_up_w[25:0]) :
			$past(chk_dn_w[25:0]));
	endproperty
	a_pre_addr: assert property (p_pre_addr)
		else $error("pre-indexed address is not base plus or minus offset");

	property p_post_addr;
		@(posedge pclk) disable iff (!presetn)
		(claim_ok_w && !ag_if.illegal && !instr_r[24] && chk_gpr_w) |=>
			mem_addr == $past(base_r[25:0]);
	endproperty
	a_post_addr: assert property (p_post_addr)
		else $error("post-indexed transfer did not use the old base");

	property p_wb_pre;
		@(posedge pclk) disable iff (!presetn)
		(end_w && instr_r[24]) |=> base_wb_valid == $past(instr_r[21]);
	endproperty
	a_wb_pre: assert property (p_wb_pre)
		else $error("pre-indexed write-back does not follow w");

	property p_wb_post;
		@(posedge pclk) disable iff (!presetn)
		(end_w && !instr_r[24] && chk_gpr_w) |=> base_wb_valid &&
			base_wb_data == (instr_r[23] ? $past(chk_up_w) :
			$past(chk_dn_w));
	endproperty
	a_wb_post: assert property (p_wb_post)
		else $error("post-indexed transfer missed its write-back");

	property p_step;
		@(posedge pclk) disable iff (!presetn)
		(word_w && !cp_last && !mem_abort) |=>
			mem_addr == $past(mem_addr) + 26'h000_0004 && mem_req;
	endproperty
	a_step: assert property (p_step)
		else $error("next word address is not one word higher");

	property p_pc_base;
		@(posedge pclk) disable iff (!presetn)
		(claim_ok_w && !ag_if.illegal && !instr_r[24] && !chk_gpr_w) |=>
			mem_addr == $past(pc_r) + 26'h000_0008;
	endproperty
	a_pc_base: assert property (p_pc_base)
		else $error("pc base is not eight bytes ahead");

	property p_translate_n;
		@(posedge pclk) disable iff (!presetn)
		(mem_req && !user_r) |-> translate_n == !(!instr_r[24] &&
			instr_r[21]);
	endproperty
	a_translate_n: assert property (p_translate_n)
		else $error("translate pin wrong in privileged transfer");

	property p_addr_exc;
		@(posedge pclk) disable iff (!presetn)
		(claim_ok_w && ag_if.illegal) |=> trap_addr_exc && !mem_req
			##1 !trap_addr_exc;
	endproperty
	a_addr_exc: assert property (p_addr_exc)
		else $error("illegal first address did not trap exactly once");

	property p_no_late_exc;
		@(posedge pclk) disable iff (!presetn)
		mem_req |-> !trap_addr_exc;
	endproperty
	a_no_late_exc: assert property (p_no_late_exc)
		else $error("address exception raised during the data phase");

	property p_abort;
		@(posedge pclk) disable iff (!presetn)
		(word_w && mem_abort) |=> trap_data_abort && !mem_req &&
			base_wb_valid == $past(ag_if.wb_en) &&
			words_r == $past(words_r) + 32'h0000_0001;
	endproperty
	a_abort: assert property (p_abort)
		else $error("data abort did not trap with write-back");

	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
		(word_w && !cp_last && !mem_abort && &mem_addr[25:2]) |=>
			mem_addr[25:2] == 24'h00_0000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("address did not wrap inside the address space");
endmodule

/* File: sim/cls_cp_model.sv */
// coprocessor and memory partner for the load/store address unit
// assumes: same pclk as the unit, bench sets abort_en and slow
`timescale 1ns/100ps
module cls_cp_model
	import cls_pkg::*;
#(parameter logic [3:0] CP_NUM = 4'h1)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// coprocessor handshake
	input wire logic [31:0] cp_instr,
	input wire logic cp_valid,
	output logic cp_accept,
	output logic cp_last,
	// memory handshake
	input wire cls_addr_t mem_addr,
	input wire logic mem_req,
	output logic mem_ack,
	output logic mem_abort,
	// bench controls and records
	input wire logic abort_en,
	input wire logic slow,
	output logic [7:0] words,
	output cls_addr_t first_a,
	output cls_addr_t last_a
);
	logic [1:0] left;
	logic gap;
	// claim, then one word per ack; slow mode answers every other cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cp_accept <= 1'b0;
			mem_ack <= 1'b0;
			left <= 2'h0;
			words <= 8'h00;
			gap <= 1'b0;
			first_a <= 26'h0;
			last_a <= 26'h0;
		end else begin
			gap <= ~gap;
			// answer only our own number, once per offer
			cp_accept <= cp_valid && !cp_accept && cp_instr[11:8] == CP_NUM;
			mem_ack <= mem_req && !mem_ack && !cp_accept && (!slow || gap);
			if (cp_accept) begin
				left <= cp_instr[22] ? 2'h3 : 2'h1;
				words <= 8'h00;
			end
			if (mem_ack) begin
				words <= words + 8'h01;
				last_a <= mem_addr;
				if (words == 8'h00) begin
					first_a <= mem_addr;
				end
				// an abort ends our part, so a retry starts clean
				left <= mem_abort ? 2'h0 : left - 2'h1;
			end
		end
	end
	// both qualifiers are only meaningful beside an ack
	assign cp_last = mem_ack && left == 2'h1;
	assign mem_abort = mem_ack && abort_en;
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the coprocessor load/store address unit
// assumes: apb master here, partner model on the far side
`timescale 1ns/100ps
module testbench
	import cls_pkg::*;
;
	typedef struct {
		logic [31:0] ins;
		logic [31:0] base;
		logic [31:0] pc;
		logic [3:0] flg;
		logic usr;
		logic [1:0] kind;
		logic [31:0] ea;
		logic [31:0] ewb;
	} cls_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic abort_en = 1'b0;
	logic slow = 1'b0;
	logic [31:0] prdata, cp_instr, base_wb_data, rd, wb_d;
	logic pready, pslverr, cp_valid, cp_accept, cp_last, mem_req;
	logic mem_write, translate_n, mem_ack, mem_abort, base_wb_valid;
	logic trap_addr_exc, trap_data_abort, trap_undef, er, tn_seen, mw_seen;
	logic [3:0] base_wb_reg, wb_r;
	logic [7:0] words;
	cls_addr_t mem_addr, first_a, last_a;
	int fails = 0;
	int samples_checked = 0;
	int wb_cnt, exc_cnt, abt_cnt, und_cnt, nw;
	cls_row_t rows[$];
	cls_row_t r;
	cls_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cp_instr(cp_instr), .cp_valid(cp_valid), .cp_accept(cp_accept),
		.cp_last(cp_last), .mem_addr(mem_addr), .mem_req(mem_req),
		.mem_write(mem_write), .translate_n(translate_n), .mem_ack(mem_ack),
		.mem_abort(mem_abort), .base_wb_valid(base_wb_valid),
		.base_wb_reg(base_wb_reg), .base_wb_data(base_wb_data),
		.trap_addr_exc(trap_addr_exc), .trap_data_abort(trap_data_abort),
		.trap_undef(trap_undef));
	cls_cp_model partner (.pclk(pclk), .presetn(presetn),
		.cp_instr(cp_instr), .cp_valid(cp_valid), .cp_accept(cp_accept),
		.cp_last(cp_last), .mem_addr(mem_addr), .mem_req(mem_req),
		.mem_ack(mem_ack), .mem_abort(mem_abort), .abort_en(abort_en),
		.slow(slow), .words(words), .first_a(first_a), .last_a(last_a));
	always #5 pclk = ~pclk;
	// watch pulses and the level of translate_n while a word moves
	always @(posedge pclk) begin
		if (base_wb_valid === 1'b1) begin
			wb_cnt++;
			wb_d = base_wb_data;
			wb_r = base_wb_reg;
		end
		if (mem_req === 1'b1 && mem_ack === 1'b1) begin
			tn_seen = translate_n;
			mw_seen = mem_write;
		end
		exc_cnt += (trap_addr_exc === 1'b1);
		abt_cnt += (trap_data_abort === 1'b1);
		und_cnt += (trap_undef === 1'b1);
	end
	task print_verdict;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			if (++n > 20) begin
				fails++;
				print_verdict;
			end
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// row builder: coprocessor number one, load bit is p xor u
	task add(input logic [3:0] c, input logic p, u, n, w,
		input logic [3:0] rn, input logic [7:0] off,
		input logic [31:0] b, pc, input logic [3:0] f,
		input logic us, input logic [1:0] k, input logic [31:0] ea, wb);
		rows.push_back('{{c, 3'h6, p, u, n, w, p ^ u, rn, 4'h1, 4'h1, off},
			b, pc, f, us, k, ea, wb});
	endtask
	// load one row, start it and poll status until idle with a verdict
	task run(input int i);
		int n;
		r = rows[i];
		apb(1'b1, 8'h14, 32'h3e);
		apb(1'b1, 8'h10, {28'h0, r.flg});
		apb(1'b1, 8'h0c, r.pc);
		apb(1'b1, 8'h08, r.base);
		apb(1'b1, 8'h04, r.ins);
		wb_cnt = 0;
		exc_cnt = 0;
		abt_cnt = 0;
		und_cnt = 0;
		apb(1'b1, 8'h00, {30'h0, r.usr, 1'b1});
		n = 0;
		do begin
			apb(1'b0, 8'h14, 32'h0);
			n++;
		end while ((rd[0] !== 1'b0 || rd[5:1] === 5'h0) && n < 40);
		// judge the last status seen, not the count, so a late finish passes
		if (rd[0] !== 1'b0 || rd[5:1] === 5'h0) begin
			fails++;
			print_verdict;
		end
	endtask
	initial begin
		add(4'he,1,1,0,0,4'h2,8'h04,32'h1000,0,4'h0,0,0,32'h1010,0);
		add(4'he,1,0,0,1,4'h3,8'hff,32'h2000,0,4'h0,0,0,32'h1c04,32'h1c04);
		add(4'he,0,1,0,0,4'h5,8'h02,32'h3000,0,4'h0,1,0,32'h3000,32'h3008);
		add(4'he,0,0,0,1,4'h1,8'h01,32'h4000,0,4'h0,0,0,32'h4000,32'h3ffc);
		add(4'he,1,1,0,0,4'hf,8'h01,32'hffffffff,32'h100,4'hf,0,0,32'h10c,0);
		add(4'h0,1,1,0,0,4'h2,8'h04,32'h1000,0,4'h0,0,1,0,0);
		add(4'h0,1,1,0,1,4'h6,8'h00,32'h5000,0,4'h4,0,0,32'h5000,32'h5000);
		add(4'he,1,1,1,0,4'h7,8'h00,32'h3fffffc,0,4'h0,0,0,32'h3fffffc,0);
		add(4'he,1,1,0,0,4'h2,8'h00,32'hfc000000,0,4'h0,0,2,0,0);
		add(4'he,1,0,0,0,4'h2,8'h01,32'h4000000,0,4'h0,0,0,32'h3fffffc,0);
		add(4'he,0,1,0,0,4'h2,8'h01,32'h3fffffc,0,4'h0,0,0,32'h3fffffc,
			32'h4000000);
		// post-indexed pc base, then the rarer condition codes
		add(4'he,0,1,0,0,4'hf,8'h01,32'h0,32'h200,4'h0,0,0,32'h208,32'h20c);
		add(4'h8,1,1,0,0,4'h2,8'h01,32'h1000,0,4'h2,0,0,32'h1004,0);
		add(4'hb,1,1,0,0,4'h2,8'h01,32'h1000,0,4'h9,0,1,0,0);
		add(4'hf,1,1,0,0,4'h2,8'h01,32'h1000,0,4'h0,0,1,0,0);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		chk(translate_n, 1'b1);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		// ordinary rows, alternating prompt and slow memory
		for (int i = 0; i < 15; i++) begin
			slow <= i[0];
			run(i);
			nw = r.kind == 2'h0 ? (r.ins[22] ? 3 : 1) : 0;
			chk(rd[3:2], {r.kind == 2'h2, r.kind == 2'h1});
			chk(exc_cnt, r.kind == 2'h2);
			chk(wb_cnt, nw > 0 && (!r.ins[24] || r.ins[21]));
			if (nw > 0) begin
				chk(words, nw);
				chk(first_a, r.ea[25:0]);
				chk(last_a, 26'(r.ea + 4 * (nw - 1)));
				chk(tn_seen, !(r.usr || (!r.ins[24] && r.ins[21])));
				chk(mw_seen, !r.ins[20]);
				if (!r.ins[24] || r.ins[21]) begin
					chk(wb_d, r.ewb);
					chk(wb_r, r.ins[19:16]);
				end
				apb(1'b0, 8'h1c, 32'h0);
				chk(rd, r.ea);
			end
		end
		// memory abort on a post-indexed load: trap plus write-back
		add(4'he,0,1,0,0,4'h4,8'h01,32'h6000,0,4'h0,0,0,32'h6000,32'h6004);
		abort_en <= 1'b1;
		run(15);
		chk(rd[4], 1'b1);
		chk(abt_cnt, 1);
		chk(wb_cnt, 1);
		chk(wb_d, 32'h6004);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h6004);
		apb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h1);
		abort_en <= 1'b0;
		// nobody claims coprocessor two
		add(4'he,1,1,0,0,4'h2,8'h00,32'h1000,0,4'h0,0,0,0,0);
		rows[16].ins[11:8] = 4'h2;
		run(16);
		chk(rd[5], 1'b1);
		chk(und_cnt, 1);
		chk(wb_cnt, 0);
		// reset while an offer stands: offer withdrawn, registers at rest
		apb(1'b1, 8'h00, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		chk(cp_valid, 1'b0);
		chk(translate_n, 1'b1);
		presetn <= 1'b1;
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		// unmapped address
		apb(1'b0, 8'h40, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		print_verdict;
	end
endmodule
